// ---- ddrsp_top.sv ----
// burst-four double data rate memory with separate read and write ports
// Summary of operation
// - 512Kx36 or 1Mx18 organisation, widths follow
// - independent read and write paths, concurrent
// - every burst is exactly four beats
// - operations start at input clock rise
// - read and write addresses on alternating input rises
// - input rise takes address, selects, beats 1,3
// - complementary input rise takes beats 2,4
// - per-beat byte masks suppress byte storage
// - first write beat one cycle after command
// - second write beat on next complementary rise
// - write data transfer spans two cycles
// - read beats 1,3 on complementary output rises, positive ones with dll off
// - read beats 2,4 on positive output rises, complementary ones with dll off
// - output clocks both high: use input clocks
// - read data transfer spans two cycles
// - echo clocks coincide with read beats
// - low write select starts write cycle
// - address ignored when deselected
// - echo clocks run freely, also when idle
// - dll off gives shorter read latency
`timescale 1ns/1ns
`default_nettype none
module ddrsp_top (
	input  wire logic                         clk_i,
	input  wire logic                         reset_i,
	input  wire logic                         k_i,
	input  wire logic                         k_n_i,
	input  wire logic                         c_i,
	input  wire logic                         c_n_i,
	input  wire logic                         read_sel_n_i,
	input  wire logic                         write_sel_n_i,
	input  wire logic                         dll_off_n_i,
	input  wire logic [ddrsp_pkg::AW-1:0]     location_in_i,
	input  wire logic [ddrsp_pkg::NB-1:0]     lane_mask_n_i,
	input  wire logic [ddrsp_pkg::DW-1:0]     in_beats_i,
	output var  logic [ddrsp_pkg::DW-1:0]     out_beats_o,
	output var  logic                         out_beats_oe_o,
	output var  logic                         return_strobe_pos_o,
	output var  logic                         return_strobe_neg_o
);
	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	ddrsp_pkg::ddrsp_pins_s pins_raw;
	ddrsp_pkg::ddrsp_pins_s pins_s1_r;
	ddrsp_pkg::ddrsp_pins_s pins_s2_r;
	ddrsp_pkg::ddrsp_pins_s pins_s3_r;

	assign pins_raw = '{k: k_i, k_n: k_n_i, c: c_i, c_n: c_n_i, rd_n: read_sel_n_i,
		wr_n: write_sel_n_i, dll_off_n: dll_off_n_i, loc: location_in_i,
		mask_n: lane_mask_n_i, data: in_beats_i};

	// reset to all ones so a high clock pin gives no false edge
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pins_s1_r <= '1;
			pins_s2_r <= '1;
			pins_s3_r <= '1;
		end else begin
			pins_s1_r <= pins_raw;
			pins_s2_r <= pins_s1_r;
			pins_s3_r <= pins_s2_r;
		end
	end

	// data and strobes share the same delay, so beats line up with edges
	wire k_rise   = pins_s2_r.k & ~pins_s3_r.k;
	wire k_n_rise = pins_s2_r.k_n & ~pins_s3_r.k_n;
	wire c_rise   = pins_s2_r.c & ~pins_s3_r.c;
	wire c_n_rise = pins_s2_r.c_n & ~pins_s3_r.c_n;
	wire use_k    = pins_s2_r.c & pins_s2_r.c_n;
	wire opos     = use_k ? pins_s2_r.k : pins_s2_r.c;
	wire oneg     = use_k ? pins_s2_r.k_n : pins_s2_r.c_n;
	wire out_ev   = use_k ? (k_rise | k_n_rise) : (c_rise | c_n_rise);
	wire [ddrsp_pkg::CNT_W-1:0] lat = pins_s2_r.dll_off_n ? ddrsp_pkg::LAT_DLL_ON
		: ddrsp_pkg::LAT_DLL_OFF;

	// ****************************************************************
	// command capture
	// ****************************************************************
	ddrsp_pkg::ddrsp_phase_e phase_r;
	ddrsp_pkg::ddrsp_phase_e phase_nxt;

	// phase alternates on every input rise
	assign phase_nxt = (phase_r == ddrsp_pkg::PH_READ) ? ddrsp_pkg::PH_WRITE
		: ddrsp_pkg::PH_READ;
	wire rd_cmd = k_rise & (phase_r == ddrsp_pkg::PH_READ) & ~pins_s2_r.rd_n;
	wire wr_cmd = k_rise & (phase_r == ddrsp_pkg::PH_WRITE) & ~pins_s2_r.wr_n;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			phase_r <= ddrsp_pkg::PH_READ;
		end else if (k_rise) begin
			phase_r <= phase_nxt;
		end
	end

	// ****************************************************************
	// storage array
	// ****************************************************************
	logic [ddrsp_pkg::DW-1:0]      mem [0:ddrsp_pkg::WORDS-1];
	logic [ddrsp_pkg::WORD_AW-1:0] widx;
	logic [ddrsp_pkg::DW-1:0]      wold;
	logic [ddrsp_pkg::DW-1:0]      wword;
	logic                          wr_en;

	assign wold = mem[widx];

	genvar gl;
	generate
		for (gl = 0; gl < ddrsp_pkg::NB; gl++) begin : g_lane
			// masked lanes keep the stored byte
			assign wword[gl*ddrsp_pkg::LANE_W +: ddrsp_pkg::LANE_W] = pins_s2_r.mask_n[gl]
				? wold[gl*ddrsp_pkg::LANE_W +: ddrsp_pkg::LANE_W]
				: pins_s2_r.data[gl*ddrsp_pkg::LANE_W +: ddrsp_pkg::LANE_W];
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (wr_en) begin
			mem[widx] <= wword;
		end
	end

	// ****************************************************************
	// write path
	// ****************************************************************
	ddrsp_pkg::ddrsp_wr_slot_s      wpend_r;
	ddrsp_pkg::ddrsp_wr_slot_s      wpend_nxt;
	ddrsp_pkg::ddrsp_wr_slot_s      wact_r;
	ddrsp_pkg::ddrsp_wr_slot_s      wact_nxt;
	logic [ddrsp_pkg::BEAT_W-1:0]   wbeat_r;
	logic [ddrsp_pkg::BEAT_W-1:0]   wbeat_nxt;

	// pending slot is the write buffer; active slot is the burst in flight
	wire wb1 = k_rise & wpend_r.valid & ~wact_r.valid;
	wire wb2 = k_n_rise & wact_r.valid & (wbeat_r == ddrsp_pkg::BEAT_SECOND);
	wire wb3 = k_rise & wact_r.valid & (wbeat_r == ddrsp_pkg::BEAT_THIRD);
	wire wb4 = k_n_rise & wact_r.valid & (wbeat_r == ddrsp_pkg::BEAT_LAST);

	assign wr_en = wb1 | wb2 | wb3 | wb4;
	assign widx  = wb1 ? {wpend_r.addr, ddrsp_pkg::BEAT_FIRST} : {wact_r.addr, wbeat_r};

	assign wpend_nxt = wr_cmd ? '{valid: 1'b1, addr: pins_s2_r.loc}
		: (wb1 ? '{valid: 1'b0, addr: wpend_r.addr} : wpend_r);
	assign wact_nxt  = wb1 ? '{valid: 1'b1, addr: wpend_r.addr}
		: (wb4 ? '{valid: 1'b0, addr: wact_r.addr} : wact_r);
	assign wbeat_nxt = wb1 ? ddrsp_pkg::BEAT_SECOND
		: ((wb2 | wb3 | wb4) ? wbeat_r + ddrsp_pkg::BEAT_STEP : wbeat_r);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wpend_r <= '0;
			wact_r  <= '0;
			wbeat_r <= ddrsp_pkg::BEAT_FIRST;
		end else begin
			wpend_r <= wpend_nxt;
			wact_r  <= wact_nxt;
			wbeat_r <= wbeat_nxt;
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	ddrsp_pkg::ddrsp_rd_slot_s     slot_r   [ddrsp_pkg::RD_SLOTS];
	ddrsp_pkg::ddrsp_rd_slot_s     slot_nxt [ddrsp_pkg::RD_SLOTS];
	logic                          drv      [ddrsp_pkg::RD_SLOTS];
	logic [ddrsp_pkg::WORD_AW-1:0] ridx     [ddrsp_pkg::RD_SLOTS];
	logic                          ld_sel_r;

	// two slots let a new read start while the last one still drains
	genvar gs;
	generate
		for (gs = 0; gs < ddrsp_pkg::RD_SLOTS; gs++) begin : g_slot
			wire ld   = rd_cmd & (ld_sel_r == 1'(gs));
			wire [ddrsp_pkg::CNT_W-1:0] lim = ddrsp_pkg::CNT_W'(lat + ddrsp_pkg::BURST_EDGES);
			wire in_win = slot_r[gs].valid & (slot_r[gs].cnt >= lat) & (slot_r[gs].cnt < lim);
			wire done = (slot_r[gs].cnt == ddrsp_pkg::CNT_W'(lim - ddrsp_pkg::CNT_ONE));
			assign drv[gs]  = out_ev & in_win;
			assign ridx[gs] = {slot_r[gs].addr, ddrsp_pkg::BEAT_W'(slot_r[gs].cnt - lat)};
			assign slot_nxt[gs] = ld ? '{valid: 1'b1, addr: pins_s2_r.loc, cnt: ddrsp_pkg::CNT_ZERO}
				: ((out_ev & slot_r[gs].valid)
				? '{valid: ~done, addr: slot_r[gs].addr,
					cnt: slot_r[gs].cnt + ddrsp_pkg::CNT_ONE}
				: slot_r[gs]);
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					slot_r[gs] <= '0;
				end else begin
					slot_r[gs] <= slot_nxt[gs];
				end
			end
		end
	endgenerate

	wire                          any_drv = drv[0] | drv[1];
	wire [ddrsp_pkg::WORD_AW-1:0] rsel    = drv[0] ? ridx[0] : ridx[1];
	// fetched at beat time, so earlier buffered write beats are already merged
	wire [ddrsp_pkg::DW-1:0]      rdata   = mem[rsel];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ld_sel_r <= 1'b0;
		end else if (rd_cmd) begin
			ld_sel_r <= ~ld_sel_r;
		end
	end

	// ****************************************************************
	// output registers
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			out_beats_o    <= '0;
			out_beats_oe_o <= 1'b0;
		end else if (out_ev) begin
			out_beats_o    <= any_drv ? rdata : out_beats_o;
			out_beats_oe_o <= any_drv;
		end
	end

	// echoes follow the timing clock pair, idle or not
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			return_strobe_pos_o <= 1'b0;
			return_strobe_neg_o <= 1'b0;
		end else begin
			return_strobe_pos_o <= opos;
			return_strobe_neg_o <= oneg;
		end
	end
endmodule : ddrsp_top
`default_nettype wire

// ---- ddrsp_pkg.sv ----
// constants, structs and enums shared by the burst-four split-port memory
// ****************************************************************
// organisation
// ****************************************************************
package ddrsp_pkg;
	// organisation select: 1 gives 512K x 36, 0 gives 1M x 18
	localparam bit             ORG_X36     = 1'b1;
	localparam int             DW          = ORG_X36 ? 36 : 18;
	localparam int             LANE_W      = 9;
	localparam int             NB          = DW / LANE_W;
	localparam int             WORD_AW     = ORG_X36 ? 19 : 20;
	localparam int             BEAT_W      = 2;
	localparam int             AW          = WORD_AW - BEAT_W;
	localparam int             WORDS       = 1 << WORD_AW;
	localparam int             CNT_W       = 3;
	localparam int             RD_SLOTS    = 2;
	// ****************************************************************
	// burst timing, counted in output clock rising edges after the command
	// ****************************************************************
	localparam logic [CNT_W-1:0] LAT_DLL_ON   = 3'h2;
	localparam logic [CNT_W-1:0] LAT_DLL_OFF  = 3'h1;
	localparam logic [CNT_W-1:0] BURST_EDGES  = 3'h4;
	localparam logic [CNT_W-1:0] CNT_ZERO     = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE      = 3'h1;
	localparam logic [BEAT_W-1:0] BEAT_FIRST  = 2'h0;
	localparam logic [BEAT_W-1:0] BEAT_SECOND = 2'h1;
	localparam logic [BEAT_W-1:0] BEAT_THIRD  = 2'h2;
	localparam logic [BEAT_W-1:0] BEAT_LAST   = 2'h3;
	localparam logic [BEAT_W-1:0] BEAT_STEP   = 2'h1;
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic {PH_READ, PH_WRITE} ddrsp_phase_e;
	typedef struct packed {
		logic          k;
		logic          k_n;
		logic          c;
		logic          c_n;
		logic          rd_n;
		logic          wr_n;
		logic          dll_off_n;
		logic [AW-1:0] loc;
		logic [NB-1:0] mask_n;
		logic [DW-1:0] data;
	} ddrsp_pins_s;
	typedef struct packed {
		logic             valid;
		logic [AW-1:0]    addr;
		logic [CNT_W-1:0] cnt;
	} ddrsp_rd_slot_s;
	typedef struct packed {
		logic          valid;
		logic [AW-1:0] addr;
	} ddrsp_wr_slot_s;
endpackage : ddrsp_pkg

// ---- ddrsp_ctrl_model.sv ----
// controller-side clock source: input clock pair and output clock pair
`timescale 1ns/1ns
`default_nettype none
module ddrsp_ctrl_model (
	input  wire logic tie_c_i,
	output var  logic k_o,
	output var  logic k_n_o,
	output var  logic c_o,
	output var  logic c_n_o
);
	// odd start offset keeps every pair edge 20 ns ahead of a system clock rise
	initial begin
		k_o = 1'b0;
		#30;
		forever #400 k_o = ~k_o;
	end
	assign k_n_o = ~k_o;
	assign c_o   = tie_c_i | k_o;
	assign c_n_o = tie_c_i | k_n_o;
endmodule : ddrsp_ctrl_model
`default_nettype wire

// ---- ddrsp_top_sva.sv ----
// pin-level assertions for the split-port burst-four memory
`timescale 1ns/1ns
`default_nettype none
module ddrsp_top_sva (
	input wire logic                     clk_i,
	input wire logic                     reset_i,
	input wire logic                     k_i,
	input wire logic                     c_i,
	input wire logic                     c_n_i,
	input wire logic                     read_sel_n_i,
	input wire logic                     dll_off_n_i,
	input wire logic [ddrsp_pkg::DW-1:0] out_beats_o,
	input wire logic                     out_beats_oe_o,
	input wire logic                     return_strobe_pos_o,
	input wire logic                     return_strobe_neg_o
);
	logic       k_q_r;
	logic       ph_wr_r;
	logic       rd_cmd;
	logic [5:0] since_rd_r;
	logic [5:0] oe_run_r;
	// raw pin edges: the design sees the same sample two flops later
	assign rd_cmd = k_i & ~k_q_r & ~ph_wr_r & ~read_sel_n_i;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			k_q_r      <= 1'b1;
			ph_wr_r    <= 1'b0;
			since_rd_r <= 6'h3F;
			oe_run_r   <= 6'h00;
		end else begin
			k_q_r      <= k_i;
			ph_wr_r    <= ph_wr_r ^ (k_i & ~k_q_r);
			since_rd_r <= rd_cmd ? 6'h00 : since_rd_r + {5'h00, since_rd_r != 6'h3F};
			oe_run_r   <= out_beats_oe_o ? oe_run_r + 6'h01 : 6'h00;
		end
	end
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_on_lat;  ##[14:17] $rose(out_beats_oe_o); endsequence
	sequence s_off_lat; ##[10:13] $rose(out_beats_oe_o); endsequence
	property p_lat_on;  rd_cmd && dll_off_n_i && !out_beats_oe_o |-> s_on_lat; endproperty
	property p_lat_off; rd_cmd && !dll_off_n_i && !out_beats_oe_o |-> s_off_lat; endproperty
	property p_echo_pos; !c_n_i && $rose(c_i) |-> ##[2:4] $rose(return_strobe_pos_o); endproperty
	property p_echo_neg; !c_i && $rose(c_n_i) |-> ##[2:4] $rose(return_strobe_neg_o); endproperty
	property p_echo_k; c_i && c_n_i && $rose(k_i) |-> ##[2:4] $rose(return_strobe_pos_o); endproperty
	property p_burst; $fell(out_beats_oe_o) |-> oe_run_r[3:0] == 4'h0 && oe_run_r != 6'h00;
	endproperty
	property p_stands; $rose(out_beats_oe_o) |=> $stable(out_beats_o) [*3]; endproperty
	property p_idle; out_beats_oe_o |-> since_rd_r inside {[6'h09:6'h1F]}; endproperty
	property p_edge; out_beats_oe_o && $changed(out_beats_o) |-> $changed(return_strobe_pos_o)
		|| $past(return_strobe_pos_o) != $past(return_strobe_pos_o, 2); endproperty
	a_lat_on: assert property (p_lat_on) else $error("read latency wrong");
	a_lat_off: assert property (p_lat_off) else $error("short latency wrong");
	a_echo_pos: assert property (p_echo_pos) else $error("echo pos stuck");
	a_echo_neg: assert property (p_echo_neg) else $error("echo neg stuck");
	a_echo_k: assert property (p_echo_k) else $error("echo not on input clock");
	a_burst: assert property (p_burst) else $error("burst not four beats");
	a_stands: assert property (p_stands) else $error("beat not held");
	a_idle: assert property (p_idle) else $error("driven with no read");
	a_edge: assert property (p_edge) else $error("beat off echo edge");
endmodule : ddrsp_top_sva
bind ddrsp_top ddrsp_top_sva u_sva (.clk_i, .reset_i, .k_i, .c_i, .c_n_i, .read_sel_n_i,
	.dll_off_n_i, .out_beats_o, .out_beats_oe_o, .return_strobe_pos_o, .return_strobe_neg_o);
`default_nettype wire

// ---- ddrsp_top_test.sv ----
// self-checking bench for the split-port burst-four memory
`timescale 1ns/1ns
`default_nettype none
module ddrsp_top_test;
	typedef struct packed {logic [ddrsp_pkg::AW-1:0] a; logic [15:0] m;} ddrsp_row_s;
	logic                     clk_i = 1'b0;
	logic                     reset_i = 1'b1;
	logic                     k, k_n, c, c_n, oe, sp, sn;
	logic                     tie_c = 1'b0, rd_n = 1'b1, wr_n = 1'b1, dll_n = 1'b1;
	logic                     sp_q = 1'b0, seen = 1'b0;
	logic [ddrsp_pkg::AW-1:0] loc = '0;
	logic [ddrsp_pkg::NB-1:0] mask_n = '1;
	logic [ddrsp_pkg::DW-1:0] din = '0, q;
	logic [ddrsp_pkg::DW-1:0] got[$], ref_mem[int];
	int                       miscompares = 0, samples_checked = 0;
	// last row is fully masked: nothing may change
	ddrsp_row_s rows [4] = '{'{17'h00005, 16'h0000}, '{17'h1FFFF, 16'h0000},
		'{17'h00005, 16'h5A3C}, '{17'h00005, 16'hFFFF}};
	ddrsp_top uut (.clk_i, .reset_i, .k_i(k), .k_n_i(k_n), .c_i(c), .c_n_i(c_n),
		.read_sel_n_i(rd_n), .write_sel_n_i(wr_n), .dll_off_n_i(dll_n), .location_in_i(loc),
		.lane_mask_n_i(mask_n), .in_beats_i(din), .out_beats_o(q), .out_beats_oe_o(oe),
		.return_strobe_pos_o(sp), .return_strobe_neg_o(sn));
	ddrsp_ctrl_model ctl (.tie_c_i(tie_c), .k_o(k), .k_n_o(k_n), .c_o(c), .c_n_o(c_n));
	always #50 clk_i = ~clk_i;
	// take a beat one cycle after each echo edge, so a one-cycle skew still lands
	always @(negedge clk_i) begin
		if (seen && oe === 1'b1)
			got.push_back(q);
		seen = (sp !== sp_q);
		sp_q = sp;
	end
	function automatic logic [ddrsp_pkg::DW-1:0] mk(input int r, input int b);
		return {9'(r*16+b*4+3), 9'(r*16+b*4+2), 9'(r*16+b*4+1), 9'(r*16+b*4)};
	endfunction : mk
	task automatic check(input string what, input logic [ddrsp_pkg::DW-1:0] exp, sv);
		samples_checked++;
		if (sv !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, sv);
		end
	endtask : check
	// one half of an input clock cycle: set up just after a pin edge, taken at the next
	task automatic half(input logic r, w, input logic [ddrsp_pkg::AW-1:0] a,
		input logic [3:0] m, input logic [ddrsp_pkg::DW-1:0] d);
		@(k);
		@(negedge clk_i);
		rd_n = r;
		wr_n = w;
		loc = a;
		mask_n = m;
		din = d;
	endtask : half
	// twenty halves from a read-phase rise; even count keeps the slot phase aligned
	task automatic seq(input bit wr, rl, re, bad, input ddrsp_row_s row, input int r);
		logic [ddrsp_pkg::DW-1:0] d;
		logic                     rv, wv;
		got.delete();
		for (int b = 0; b < 16 && wr; b++) begin
			d = mk(r, b / 4);
			if (!row.m[b])
				ref_mem[{row.a, 2'(b / 4)}][9*(b%4) +: 9] = d[9*(b%4) +: 9];
		end
		for (int h = 0; h < 20; h++) begin
			rv = !((rl && h == 8) || (re && h == 4) || (bad && h == 2));
			wv = !((wr && h == 2) || (bad && h == 0));
			half(rv, wv, (rv && wv) ? ~row.a : row.a, (h >= 4 && h < 8 && wr) ?
				row.m[4*(h-4) +: 4] : 4'h0, (h >= 4 && h < 8) ? mk(r, h - 4) : ~mk(r, h));
		end
		check("beat count", (rl || re) ? 36'h4 : 36'h0, ddrsp_pkg::DW'(got.size()));
		check("echo pair", 36'h1, ddrsp_pkg::DW'(sp ^ sn));
		for (int b = 0; b < 4 && (rl || re); b++)
			check("read beat", ref_mem[{row.a, 2'(b)}], got[b]);
	endtask : seq
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		#400000;
		miscompares++;
		summarize();
	end
	initial begin
		repeat (5) @(negedge clk_i);
		check("oe in reset", '0, ddrsp_pkg::DW'(oe));
		check("data in reset", '0, q);
		@(posedge k);
		@(negedge clk_i);
		reset_i = 1'b0;
		foreach (rows[i])
			seq(1'b1, 1'b1, 1'b0, 1'b0, rows[i], i);
		dll_n = 1'b0;
		seq(1'b0, 1'b1, 1'b0, 1'b0, rows[0], 9);
		dll_n = 1'b1;
		tie_c = 1'b1;
		seq(1'b1, 1'b1, 1'b0, 1'b0, rows[1], 10);
		tie_c = 1'b0;
		seq(1'b1, 1'b0, 1'b1, 1'b0, rows[2], 11);
		seq(1'b0, 1'b1, 1'b0, 1'b1, rows[2], 12);
		summarize();
	end
endmodule : ddrsp_top_test
`default_nettype wire
